// file: rtl/watchdog_wakeup_pkg.sv
package watchdog_wakeup_pkg;

  // Register port geometry
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;

  // Register offsets
  localparam logic [3:0] WDT_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] RESET_FLAG_OFFSET = 4'h1;
  localparam logic [3:0] STATUS_OFFSET = 4'h2;
  localparam logic [3:0] PORTA_WAKE_OFFSET = 4'h3;
  localparam logic [3:0] WAKE_CAUSE_OFFSET = 4'h4;

  // Watchdog control layout and reset
  localparam logic [7:0] WDT_CTRL_RESET = 8'h53;
  localparam int KEY_LSB = 3;
  localparam int KEY_W = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  localparam int PERIOD_BASE_EXP = 8;
  localparam int WDT_COUNT_W = 16;

  // Reset flag layout
  localparam int KEY_FAULT_BIT = 0;
  localparam int LOW_VOLT_BIT = 2;

  // Status layout
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_POWER_DOWN_BIT = 1;
  localparam int STAT_MODE_LSB = 2;
  localparam int STAT_PENDING_BIT = 5;

  // Wake cause layout
  localparam int CAUSE_PORT_BIT = 0;
  localparam int CAUSE_IRQ_BIT = 1;
  localparam int CAUSE_WDT_BIT = 2;

  localparam logic [7:0] PORTA_WAKE_RESET = 8'h00;
  localparam logic [7:0] PORT_POWER_ON_VALUE = 8'hFF;

  // Timing
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int LOW_SPEED_RC_OSC_FREQ_HZ = 32000;
  localparam int KEY_FAULT_RESET_DELAY_NS = 1000;
  localparam int KEY_FAULT_DELAY_CYCLES =
    (KEY_FAULT_RESET_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_IDLE0 = 3'b010,
    MODE_IDLE1 = 3'b011,
    MODE_IDLE2 = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

endpackage : watchdog_wakeup_pkg

// file: rtl/watchdog_wakeup_reset_flags.sv
// Functional notes
// - Wake on port fall, interrupt, or overflow
// - Halt sets power-down flag
// - Power-up or clear instruction clears power-down
// - Idle overflow wakes, sets timeout, clears PC/SP
// - Port pin wakes only when enabled
// - Disabled or stack-full interrupt resumes after halt
// - Enabled interrupt with free stack is serviced
// - Flag already set before halt cannot wake
// - Watchdog counts low-speed RC clock
// - Timeout is 2^(8+code) slow periods
// - Key disables, enables, else resets chip
// - Bad key resets after delay, sets flag
// - Key powers up as enable pattern
// - Key fault flag cleared only by zero write
// - Running overflow resets device, sets timeout
// - Counter cleared by key fault, clear, halt
// - Power-on sets program counter to zero
// - Power-on sets port registers all high
// - Halt clears counter, runs only if enabled
// - Halt with idle bits low enters sleep
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
module watchdog_wakeup_reset_flags
  import watchdog_wakeup_pkg::*;
#(
  parameter int PORTA_W = 8,
  parameter int NUM_IRQ = 4,
  parameter int KEY_FAULT_DELAY = KEY_FAULT_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic haltExec,
  input wire logic watchdogClearInstruction,
  input wire logic fastIdleEnable,
  input wire logic slowIdleEnable,
  input wire logic [PORTA_W-1:0] portAPins,
  input wire logic [NUM_IRQ-1:0] interruptFlags,
  input wire logic [NUM_IRQ-1:0] interruptEnables,
  input wire logic stackFull,
  input wire logic lowSpeedRcOsc,
  input wire logic lowVoltageEvent,
  output power_mode_t powerMode,
  output logic powerDownFlag,
  output logic timeoutFlag,
  output logic wakeUp,
  output logic resumeAfterHalt,
  output logic serviceInterrupt,
  output logic [NUM_IRQ-1:0] serviceIrqOneHot,
  output logic pcStackClear,
  output logic chipReset,
  output logic powerOnLoad,
  output logic [7:0] portPowerOnValue
);

  localparam int DELAY_W = 16;

  typedef struct packed {
    power_mode_t mode;
    logic [7:0] wdtControl;
    logic [PORTA_W-1:0] portaWakeEnable;
    logic keyFaultFlag;
    logic lowVoltageFlag;
    logic powerDownFlag;
    logic timeoutFlag;
    logic keyFaultPending;
    logic [DELAY_W-1:0] keyFaultDelay;
    logic [WDT_COUNT_W-1:0] wdtCount;
    logic [NUM_IRQ-1:0] irqArmed;
    logic [NUM_IRQ-1:0] irqDeferred;
    logic [2:0] wakeCause;
    logic [PORTA_W-1:0] portSync1;
    logic [PORTA_W-1:0] portSync2;
    logic [PORTA_W-1:0] portPrev;
    logic lircSync1;
    logic lircSync2;
    logic lircPrev;
    logic [7:0] regRdData;
    logic wakeUp;
    logic resumeAfterHalt;
    logic serviceInterrupt;
    logic [NUM_IRQ-1:0] serviceIrqOneHot;
    logic pcStackClear;
    logic chipReset;
    logic powerOnLoad;
    logic [7:0] portPowerOnValue;
  } state_t;

  state_t s;
  state_t next_s;

  // Lowest set bit of a request vector
  function automatic logic [NUM_IRQ-1:0] lowestBit(input logic [NUM_IRQ-1:0] vec);
    logic [NUM_IRQ-1:0] pick;
    pick = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (vec[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
    return pick;
  endfunction : lowestBit

  logic [KEY_W-1:0] key;
  logic [SEL_W-1:0] periodSel;
  logic [KEY_W-1:0] writtenKey;
  logic wdtEnabled;
  logic writtenKeyValid;
  logic lircTick;
  logic [WDT_COUNT_W-1:0] timeoutLast;
  logic overflow;
  logic [PORTA_W-1:0] portFall;
  logic [NUM_IRQ-1:0] irqWake;
  logic [NUM_IRQ-1:0] irqServe;
  logic [NUM_IRQ-1:0] deferredReady;
  logic asleep;
  logic keyFaultFire;
  logic wdtClear;
  logic haltTaken;

  always_comb begin
    key = s.wdtControl[KEY_LSB +: KEY_W];
    periodSel = s.wdtControl[SEL_LSB +: SEL_W];
    writtenKey = regReq.wdata[KEY_LSB +: KEY_W];
    writtenKeyValid = (writtenKey == KEY_ENABLE) || (writtenKey == KEY_DISABLE);
    // only the enable pattern runs the counter
    wdtEnabled = (key == KEY_ENABLE);
    asleep = (s.mode != MODE_RUN);
    // Slow clock is sampled as data, never used as a clock
    // count rising edges of the synchronised slow clock
    lircTick = s.lircSync2 && !s.lircPrev;
    // terminal count is 2^(8+code) minus one
    timeoutLast = (WDT_COUNT_W'(1) << (PERIOD_BASE_EXP + int'(periodSel)))
      - WDT_COUNT_W'(1);
    // only enabled pins see a falling edge
    portFall = s.portPrev & ~s.portSync2 & s.portaWakeEnable;
    // flags already set at halt were disarmed
    irqWake = interruptFlags & s.irqArmed;
    irqServe = irqWake & interruptEnables;
    deferredReady = s.irqDeferred & interruptFlags & interruptEnables;
    keyFaultFire = s.keyFaultPending && (s.keyFaultDelay == '0);
    // halt is only taken while running
    haltTaken = haltExec && !asleep;
    // key fault, clear instruction and halt clear the count
    wdtClear = keyFaultFire || watchdogClearInstruction
      || haltTaken;
    // overflow on the tick that completes the count
    // A clear on that very tick still counts as in time
    overflow = wdtEnabled && lircTick && (s.wdtCount == timeoutLast) && !wdtClear;
  end

  always_comb begin
    next_s = s;
    next_s.wakeUp = 1'b0;
    next_s.resumeAfterHalt = 1'b0;
    next_s.serviceInterrupt = 1'b0;
    next_s.serviceIrqOneHot = '0;
    next_s.pcStackClear = 1'b0;
    next_s.chipReset = 1'b0;
    next_s.powerOnLoad = 1'b0;
    next_s.regRdData = '0;

    // Two stages before any logic sees a pin or the slow clock
    next_s.portSync1 = portAPins;
    next_s.portSync2 = s.portSync1;
    next_s.portPrev = s.portSync2;
    next_s.lircSync1 = lowSpeedRcOsc;
    next_s.lircSync2 = s.lircSync1;
    next_s.lircPrev = s.lircSync2;

    // Watchdog counter
    // halt clears it, counting only when enabled
    if (wdtClear || overflow) begin
      next_s.wdtCount = '0;
    end else if (wdtEnabled && lircTick) begin
      next_s.wdtCount = s.wdtCount + WDT_COUNT_W'(1);
    end

    // Deferred interrupts drop when the source withdraws its request
    next_s.irqDeferred = s.irqDeferred & interruptFlags;

    // Register writes
    if (regReq.write) begin
      case (regReq.addr)
        WDT_CTRL_OFFSET: begin
          next_s.wdtControl = regReq.wdata;
          // A second bad key must not restart the delay
          // a bad key arms the delayed reset
          if (!writtenKeyValid && !s.keyFaultPending) begin
            next_s.keyFaultPending = 1'b1;
            next_s.keyFaultDelay = DELAY_W'(KEY_FAULT_DELAY - 1);
          end
        end
        RESET_FLAG_OFFSET: begin
          // writing one leaves the flag alone
          if (!regReq.wdata[KEY_FAULT_BIT]) begin
            next_s.keyFaultFlag = 1'b0;
          end
          if (!regReq.wdata[LOW_VOLT_BIT]) begin
            next_s.lowVoltageFlag = 1'b0;
          end
        end
        PORTA_WAKE_OFFSET: begin
          next_s.portaWakeEnable = regReq.wdata[PORTA_W-1:0];
        end
        WAKE_CAUSE_OFFSET: begin
          next_s.wakeCause = s.wakeCause & ~regReq.wdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // Hardware sets after the software clears so a same-cycle event wins
    if (lowVoltageEvent) begin
      next_s.lowVoltageFlag = 1'b1;
    end

    if (s.keyFaultPending && !keyFaultFire) begin
      next_s.keyFaultDelay = s.keyFaultDelay - DELAY_W'(1);
    end

    // halt sets power-down and picks the low power mode
    if (haltTaken) begin
      next_s.powerDownFlag = 1'b1;
      next_s.timeoutFlag = 1'b0;
      next_s.irqArmed = ~interruptFlags;
      // both idle enables low means sleep
      case ({fastIdleEnable, slowIdleEnable})
        2'b00: begin
          next_s.mode = MODE_SLEEP;
        end
        2'b01: begin
          next_s.mode = MODE_IDLE0;
        end
        2'b11: begin
          next_s.mode = MODE_IDLE1;
        end
        2'b10: begin
          next_s.mode = MODE_IDLE2;
        end
        default: begin
          next_s.mode = MODE_SLEEP;
        end
      endcase
    end

    if (watchdogClearInstruction) begin
      next_s.powerDownFlag = 1'b0;
    end

    // any of the three sources ends a low power mode
    if (asleep) begin
      // Overflow outranks interrupts, which outrank pins
      if (overflow) begin
        // timeout wake clears only PC and stack pointer
        next_s.timeoutFlag = 1'b1;
        next_s.pcStackClear = 1'b1;
        next_s.wakeUp = 1'b1;
        next_s.mode = MODE_RUN;
        next_s.wakeCause[CAUSE_WDT_BIT] = 1'b1;
      end else if (|irqWake) begin
        next_s.wakeUp = 1'b1;
        next_s.mode = MODE_RUN;
        next_s.wakeCause[CAUSE_IRQ_BIT] = 1'b1;
        // A full stack defers even an enabled request
        if ((|irqServe) && !stackFull) begin
          // normal interrupt response right after wake
          next_s.serviceInterrupt = 1'b1;
          next_s.serviceIrqOneHot = lowestBit(irqServe);
        end else begin
          // resume after halt and hold the request
          next_s.resumeAfterHalt = 1'b1;
          next_s.irqDeferred = s.irqDeferred | irqWake;
        end
      end else if (|portFall) begin
        next_s.wakeUp = 1'b1;
        next_s.resumeAfterHalt = 1'b1;
        next_s.mode = MODE_RUN;
        next_s.wakeCause[CAUSE_PORT_BIT] = 1'b1;
      end
    end else if (overflow) begin
      // overflow while running resets the device
      next_s.chipReset = 1'b1;
      next_s.timeoutFlag = 1'b1;
    end else if ((|deferredReady) && !stackFull) begin
      // held request served once enabled with stack room
      next_s.serviceInterrupt = 1'b1;
      next_s.serviceIrqOneHot = lowestBit(deferredReady);
      next_s.irqDeferred = s.irqDeferred & ~lowestBit(deferredReady);
    end

    // delayed full reset from a corrupted key
    if (keyFaultFire) begin
      next_s.keyFaultPending = 1'b0;
      next_s.keyFaultFlag = 1'b1;
      next_s.chipReset = 1'b1;
      next_s.wdtControl = WDT_CTRL_RESET;
      next_s.mode = MODE_RUN;
      next_s.irqDeferred = '0;
    end

    // Reads answer in the following cycle
    // Unused high bits stay zero
    if (regReq.read) begin
      case (regReq.addr)
        WDT_CTRL_OFFSET: begin
          next_s.regRdData = s.wdtControl;
        end
        RESET_FLAG_OFFSET: begin
          next_s.regRdData[KEY_FAULT_BIT] = s.keyFaultFlag;
          next_s.regRdData[LOW_VOLT_BIT] = s.lowVoltageFlag;
        end
        STATUS_OFFSET: begin
          next_s.regRdData[STAT_TIMEOUT_BIT] = s.timeoutFlag;
          next_s.regRdData[STAT_POWER_DOWN_BIT] = s.powerDownFlag;
          next_s.regRdData[STAT_MODE_LSB +: 3] = s.mode;
          next_s.regRdData[STAT_PENDING_BIT] = s.keyFaultPending;
        end
        PORTA_WAKE_OFFSET: begin
          next_s.regRdData[PORTA_W-1:0] = s.portaWakeEnable;
        end
        WAKE_CAUSE_OFFSET: begin
          next_s.regRdData[2:0] = s.wakeCause;
        end
        default: begin
          next_s.regRdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      // key powers up as the enable pattern
      s.wdtControl <= WDT_CTRL_RESET;
      s.portaWakeEnable <= PORTA_WAKE_RESET[PORTA_W-1:0];
      s.mode <= MODE_RUN;
      // first cycle after release loads PC with zero
      s.powerOnLoad <= 1'b1;
      // port data and control come up all high
      s.portPowerOnValue <= PORT_POWER_ON_VALUE;
      s.portSync1 <= '1;
      s.portSync2 <= '1;
      s.portPrev <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData = s.regRdData;
  assign powerMode = s.mode;
  assign powerDownFlag = s.powerDownFlag;
  assign timeoutFlag = s.timeoutFlag;
  assign wakeUp = s.wakeUp;
  assign resumeAfterHalt = s.resumeAfterHalt;
  assign serviceInterrupt = s.serviceInterrupt;
  assign serviceIrqOneHot = s.serviceIrqOneHot;
  assign pcStackClear = s.pcStackClear;
  assign chipReset = s.chipReset;
  assign powerOnLoad = s.powerOnLoad;
  assign portPowerOnValue = s.portPowerOnValue;

endmodule : watchdog_wakeup_reset_flags

// file: verification/watchdog_wakeup_properties.sv
`timescale 1ns/100ps
module watchdog_wakeup_properties
  import watchdog_wakeup_pkg::*;
#(
  parameter int NUM_IRQ = 4,
  parameter int KEY_FAULT_DELAY = KEY_FAULT_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire reg_req_t regReq,
  input wire logic haltExec,
  input wire logic watchdogClearInstruction,
  input wire logic fastIdleEnable,
  input wire logic slowIdleEnable,
  input wire power_mode_t powerMode,
  input wire logic powerDownFlag,
  input wire logic timeoutFlag,
  input wire logic wakeUp,
  input wire logic serviceInterrupt,
  input wire logic [NUM_IRQ-1:0] serviceIrqOneHot,
  input wire logic pcStackClear,
  input wire logic chipReset,
  input wire logic [7:0] portPowerOnValue
);
  // One cycle of slack: the pulse may land on or just after the counted edge
  localparam int KF_MAX = KEY_FAULT_DELAY + 1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence haltInRun;
    haltExec && powerMode == MODE_RUN;
  endsequence
  sequence sleepHalt;
    haltInRun ##0 (!fastIdleEnable && !slowIdleEnable);
  endsequence
  sequence badKeyWrite;
    regReq.write && regReq.addr == WDT_CTRL_OFFSET &&
      regReq.wdata[7:3] != KEY_ENABLE && regReq.wdata[7:3] != KEY_DISABLE;
  endsequence

  AST_HALT_PDF: assert property (haltInRun |=> powerDownFlag && !timeoutFlag)
    else $error("halt did not set power-down");
  AST_CLR_PDF: assert property (watchdogClearInstruction && !haltExec |=> !powerDownFlag)
    else $error("clear instruction left power-down set");
  AST_SLEEP_ENTRY: assert property (sleepHalt |=> powerMode == MODE_SLEEP)
    else $error("halt with idle bits low missed sleep");
  AST_PDF_KEPT: assert property (powerDownFlag && powerMode != MODE_RUN &&
    !watchdogClearInstruction |=> powerDownFlag)
    else $error("power-down lost while asleep");
  AST_IDLE_WAKE: assert property (pcStackClear |-> wakeUp && timeoutFlag && powerDownFlag)
    else $error("overflow wake flags wrong");
  AST_SVC_ONEHOT: assert property (serviceInterrupt |-> $onehot(serviceIrqOneHot))
    else $error("service vector not one-hot");
  AST_WAKE_RUN: assert property (wakeUp |-> powerMode == MODE_RUN)
    else $error("wake without return to run");
  AST_KEY_FAULT: assert property (badKeyWrite |-> ##[KEY_FAULT_DELAY:KF_MAX] chipReset)
    else $error("bad key did not reset after delay");
  AST_PORT_VAL: assert property (portPowerOnValue == 8'hFF)
    else $error("port power-on value not all high");
endmodule : watchdog_wakeup_properties

bind watchdog_wakeup_reset_flags watchdog_wakeup_properties #(
  .NUM_IRQ(NUM_IRQ),
  .KEY_FAULT_DELAY(KEY_FAULT_DELAY)
) props (
  .clock(clock), .resetn(resetn), .regReq(regReq), .haltExec(haltExec),
  .watchdogClearInstruction(watchdogClearInstruction), .fastIdleEnable(fastIdleEnable),
  .slowIdleEnable(slowIdleEnable), .powerMode(powerMode), .powerDownFlag(powerDownFlag),
  .timeoutFlag(timeoutFlag), .wakeUp(wakeUp), .serviceInterrupt(serviceInterrupt),
  .serviceIrqOneHot(serviceIrqOneHot), .pcStackClear(pcStackClear), .chipReset(chipReset),
  .portPowerOnValue(portPowerOnValue)
);

// file: verification/watchdog_wakeup_reset_flags_tb_top.sv
`timescale 1ns/100ps
module watchdog_wakeup_reset_flags_tb_top
  import watchdog_wakeup_pkg::*;
;
  logic clock = 0, resetn = 0, haltExec = 0, watchdogClearInstruction = 0;
  logic fastIdleEnable = 0, slowIdleEnable = 0, lowSpeedRcOsc = 0, stackFull = 0;
  reg_req_t regReq = '0;
  logic [7:0] portAPins = 8'hFF, regRdData, portPowerOnValue;
  logic [3:0] interruptFlags = 4'h0, interruptEnables = 4'h0, serviceIrqOneHot;
  logic [1:0] div = 2'h0;
  power_mode_t powerMode;
  logic powerDownFlag, timeoutFlag, wakeUp, resumeAfterHalt, serviceInterrupt;
  logic pcStackClear, chipReset, powerOnLoad;
  int errorCnt = 0, nTests = 0, cyc;
  power_mode_t modeTab [4] = '{MODE_SLEEP, MODE_IDLE0, MODE_IDLE2, MODE_IDLE1};

  watchdog_wakeup_reset_flags #(.KEY_FAULT_DELAY(3)) dut (
    .clock(clock), .resetn(resetn), .regReq(regReq), .regRdData(regRdData),
    .haltExec(haltExec), .watchdogClearInstruction(watchdogClearInstruction),
    .fastIdleEnable(fastIdleEnable), .slowIdleEnable(slowIdleEnable), .portAPins(portAPins),
    .interruptFlags(interruptFlags), .interruptEnables(interruptEnables), .stackFull(stackFull),
    .lowSpeedRcOsc(lowSpeedRcOsc), .lowVoltageEvent(1'b0), .powerMode(powerMode),
    .powerDownFlag(powerDownFlag), .timeoutFlag(timeoutFlag), .wakeUp(wakeUp),
    .resumeAfterHalt(resumeAfterHalt), .serviceInterrupt(serviceInterrupt),
    .serviceIrqOneHot(serviceIrqOneHot), .pcStackClear(pcStackClear), .chipReset(chipReset),
    .powerOnLoad(powerOnLoad), .portPowerOnValue(portPowerOnValue)
  );

  always #10 clock = ~clock;
  // Slow clock of 8 system cycles keeps a 2^8 timeout near 2048 cycles
  always @(posedge clock) begin
    div <= div + 2'h1;
    if (div == 2'h3) lowSpeedRcOsc <= ~lowSpeedRcOsc;
  end

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : endSim

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock);
    regReq.write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    regReq <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock);
    regReq.read <= 1'b0;
    #1 chk(regRdData, exp);
  endtask : rd

  task automatic halt(input logic [1:0] m);
    @(posedge clock);
    haltExec <= 1'b1;
    {fastIdleEnable, slowIdleEnable} <= m;
    @(posedge clock);
    haltExec <= 1'b0;
    #1;
  endtask : halt

  task automatic clrWdt();
    @(posedge clock);
    watchdogClearInstruction <= 1'b1;
    @(posedge clock);
    watchdogClearInstruction <= 1'b0;
    #1;
  endtask : clrWdt

  // Sel: 0 wake, 1 chip reset, 2 interrupt service; n stays -1 if nothing came
  task automatic waitSig(input int w, input int lim, input bit want, output int n);
    logic s;
    n = -1;
    for (int k = 0; k < lim && n < 0; k++) begin
      @(posedge clock);
      #1;
      s = (w == 0) ? wakeUp : (w == 1) ? chipReset : serviceInterrupt;
      if (s === 1'b1) n = k;
    end
    if (want && n < 0) begin
      chk(16'h0, 16'h1);
      endSim();
    end
  endtask : waitSig

  task automatic portWake();
    @(posedge clock);
    portAPins[0] <= 1'b0;
    waitSig(0, 12, 1, cyc);
    chk(resumeAfterHalt, 1'b1);
    @(posedge clock);
    portAPins <= 8'hFF;
    repeat (4) @(posedge clock);
  endtask : portWake

  initial begin
    repeat (19) @(posedge clock);
    #1 chk(powerOnLoad, 1'b1);
    chk(portPowerOnValue, 8'hFF);
    @(posedge clock);
    resetn <= 1'b1;
    rd(4'h0, 8'h53);
    chk(powerOnLoad, 1'b0);
    chk(powerDownFlag, 1'b0);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'hA8);
    wr(4'h3, 8'h01);
    for (int i = 0; i < 4; i++) begin
      halt(i[1:0]);
      chk(powerMode, modeTab[i]);
      chk(powerDownFlag, 1'b1);
      if (i == 3) begin
        @(posedge clock);
        portAPins[1] <= 1'b0;
        waitSig(0, 12, 0, cyc);
        chk(logic'(cyc == -1), 1'b1);
      end
      portWake();
    end
    clrWdt();
    chk(powerDownFlag, 1'b0);
    halt(2'b00);
    @(posedge clock);
    interruptEnables <= 4'h4;
    interruptFlags <= 4'h4;
    waitSig(2, 12, 1, cyc);
    chk(serviceIrqOneHot, 4'h4);
    @(posedge clock);
    interruptFlags <= 4'h0;
    interruptEnables <= 4'h0;
    halt(2'b00);
    @(posedge clock);
    interruptFlags <= 4'h2;
    waitSig(0, 12, 1, cyc);
    chk({resumeAfterHalt, serviceInterrupt}, 2'b10);
    @(posedge clock);
    interruptEnables <= 4'h2;
    waitSig(2, 12, 1, cyc);
    chk(serviceIrqOneHot, 4'h2);
    @(posedge clock);
    interruptFlags <= 4'h0;
    stackFull <= 1'b1;
    halt(2'b00);
    @(posedge clock);
    interruptFlags <= 4'h2;
    waitSig(0, 12, 1, cyc);
    chk({resumeAfterHalt, serviceInterrupt}, 2'b10);
    @(posedge clock);
    stackFull <= 1'b0;
    waitSig(2, 12, 1, cyc);
    chk(serviceIrqOneHot, 4'h2);
    @(posedge clock);
    interruptFlags <= 4'h8;
    interruptEnables <= 4'h0;
    halt(2'b00);
    waitSig(0, 12, 0, cyc);
    chk(logic'(cyc == -1), 1'b1);
    portWake();
    interruptFlags <= 4'h0;
    wr(4'h0, 8'h50);
    clrWdt();
    waitSig(1, 2300, 1, cyc);
    chk(logic'(cyc > 2030 && cyc < 2070), 1'b1);
    chk(timeoutFlag, 1'b1);
    wr(4'h0, 8'h50);
    halt(2'b00);
    waitSig(0, 2300, 1, cyc);
    chk(logic'(cyc > 2030 && cyc < 2070), 1'b1);
    chk({pcStackClear, timeoutFlag, powerDownFlag}, 3'b111);
    chk(powerMode, MODE_RUN);
    rd(4'h2, 8'h03);
    rd(4'h4, 8'h07);
    wr(4'h4, 8'h07);
    rd(4'h4, 8'h00);
    clrWdt();
    wr(4'h0, 8'hF8);
    waitSig(1, 12, 1, cyc);
    chk(logic'(cyc >= 1 && cyc <= 3), 1'b1);
    rd(4'h1, 8'h01);
    rd(4'h0, 8'h53);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'hA8);
    waitSig(1, 2300, 0, cyc);
    chk(logic'(cyc == -1), 1'b1);
    endSim();
  end
endmodule : watchdog_wakeup_reset_flags_tb_top
